// ===== src/pce_pkg.sv
// Constants for the channel command engine
package pce_pkg;
  localparam int          CH_W          = 8;
  // ROM and control function command codes
  localparam logic [7:0]  CMD_READ_ROM  = 8'h33;
  localparam logic [7:0]  CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0]  CMD_CH_READ   = 8'hF5;
  localparam logic [7:0]  CMD_CH_WRITE  = 8'h5A;
  localparam logic [7:0]  CMD_WR_SEARCH = 8'hCC;
  localparam logic [7:0]  CMD_ACT_RESET = 8'hC3;
  // Register page addresses (high address byte is zero)
  localparam logic [7:0]  ADDR_HI       = 8'h00;
  localparam logic [7:0]  ADDR_OUT_LAT  = 8'h89;
  localparam logic [7:0]  ADDR_ACT_LAT  = 8'h8A;
  localparam logic [7:0]  ADDR_MASK     = 8'h8B;
  localparam logic [7:0]  ADDR_POL      = 8'h8C;
  localparam logic [7:0]  ADDR_CTRL     = 8'h8D;
  // Control/status field positions
  localparam int          CTRL_PLS_BIT  = 0;
  localparam int          CTRL_CT_BIT   = 1;
  localparam int          CTRL_PFS_BIT  = 2;
  localparam int          CTRL_PORL_BIT = 3;
  localparam int          CTRL_VCCP_BIT = 7;
  // Reset values
  localparam logic [7:0]  RST_OUT_LAT   = 8'hFF;
  localparam logic [7:0]  RST_ACT_LAT   = 8'h00;
  localparam logic [7:0]  RST_MASK      = 8'h00;
  localparam logic [7:0]  RST_POL       = 8'h00;
  localparam logic [6:0]  RST_CTRL      = 7'h08;
  // Confirmation pattern, CRC and counts
  localparam logic [7:0]  CONFIRM_BYTE  = 8'hAA;
  localparam logic [15:0] CRC16_POLY    = 16'hA001;
  localparam logic [4:0]  LAST_SAMPLE   = 5'h1F;
  localparam logic [4:0]  LAST_ROM_BYTE = 5'h07;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [2:0]  STROBE_BITS   = 3'h2;
endpackage : pce_pkg

// ===== src/pce_engine.sv
// Transaction and command layer of an eight-channel open-drain I/O slave
// Functional notes
// - Channel-access read samples all channels together, first at command MSB.
// - Next sample taken during MSB of previous status byte, 31 times per pass.
// - Inverted CRC16 follows 32 samples; first pass also covers command.
// - Sample taken during CRC MSB; read loop runs until bus reset.
// - Strobe pulses over first two LSBs of each read data byte.
// - Write loop samples at the same point; the read-back byte has no strobe.
// - Output latch changes only through the channel-access write command or a low pin in reset input mode.
// - Write loop: take data, apply, return channel state, until reset or a bad complement.
// - Data bit n drives channel n; one means transistor off.
// - Outputs change only if second byte is the exact complement.
// - Apply at last inverse bit: at sample if one, slot end if zero.
// - Successful update answered with confirmation byte AAh.
// - Strobe pulses over first two LSBs of confirmation byte.
// - Channels sampled during last confirmation bit, then sent.
// - Reset input mode with pin low forces outputs off, latch all ones.
// - Search register write takes address 8Bh..8Dh, writes data at once.
// - Address advances per byte; after 8Dh further bytes ignored.
// - Any pin transition sets that channel's activity latch.
// - Activity reset command clears all latches together.
// - After activity reset, reads return AAh until bus reset.
// - Read-ROM sends the eight ROM_ID bytes, least significant byte first.
// - Match-ROM mismatch leaves device silent until next reset.
// - Control bit 2 selects reset input (0) or strobe output (1).
`timescale 1ns/1ns
module pce_engine #(
  // Identity code, value arbitrary
  parameter logic [63:0] ROM_ID = 64'h5A00_0000_0000_0001
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      bus_reset_i,
  input  wire logic                      slot_wr_i,
  input  wire logic                      slot_bit_i,
  input  wire logic                      slot_rd_i,
  input  wire logic                      slot_end_i,
  output logic                           tx_bit_o,
  input  wire logic [pce_pkg::CH_W-1:0]  io_channel_i,
  output logic      [pce_pkg::CH_W-1:0]  io_channel_o,
  output logic      [pce_pkg::CH_W-1:0]  io_channel_oe_o,
  input  wire logic                      multipurpose_reset_pin_i,
  output logic                           multipurpose_reset_pin_o,
  output logic                           multipurpose_reset_pin_oe_o,
  input  wire logic                      vcc_powered_i,
  output logic      [7:0]                output_latch_state_o,
  output logic      [7:0]                activity_latch_state_o,
  output logic      [7:0]                search_channel_mask_o,
  output logic      [7:0]                search_polarity_select_o,
  output logic      [7:0]                control_and_status_o
);
  import pce_pkg::*;

  typedef enum logic [3:0] {
    ST_ROM_CMD, ST_READ_ROM, ST_MATCH_ROM, ST_FUNC_CMD, ST_CH_READ,
    ST_WR_DATA, ST_WR_INV, ST_WR_CONF, ST_WR_SAMPLE, ST_SRCH_ADDR,
    ST_SRCH_DATA, ST_ACT_AA, ST_IDLE
  } pce_state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic        b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = {1'b0, c[15:1]} ^ (fb ? CRC16_POLY : 16'h0000);
  endfunction

  pce_state_e  state_r,  state_nxt;
  logic [2:0]  bit_cnt_r, bit_cnt_nxt;
  logic [4:0]  byte_cnt_r, byte_cnt_nxt;
  logic [7:0]  rx_sh_r,  rx_sh_nxt;
  logic [7:0]  tx_sh_r,  tx_sh_nxt;
  logic [15:0] crc_r,    crc_nxt;
  logic [1:0]  phase_r,  phase_nxt;
  logic        miss_r,   miss_nxt;
  logic [7:0]  data_r,   data_nxt;
  logic        pend_r,   pend_nxt;
  logic        data_valid_pulse_r,   data_valid_pulse_nxt;
  logic        strobe_r, strobe_nxt;
  logic [7:0]  latch_r,  latch_nxt;
  logic [7:0]  act_r,    act_nxt;
  logic [7:0]  pin_q_r,  pin_q_nxt;
  logic [7:0]  mask_r,   mask_nxt;
  logic [7:0]  pol_r,    pol_nxt;
  logic [7:0]  ctrl_r,   ctrl_nxt;
  logic [7:0]  waddr_r,  waddr_nxt;
  logic        wdone_r,  wdone_nxt;
  logic [7:0]  rx_byte;
  logic [15:0] crc_upd;
  logic        last_bit;
  logic        act_clr;
  logic        data_valid_pulse_mode;
  logic        forced_off;

  assign data_valid_pulse_mode  = ctrl_r[CTRL_PFS_BIT];
  assign forced_off = !data_valid_pulse_mode && !multipurpose_reset_pin_i;

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    rx_sh_nxt    = rx_sh_r;
    tx_sh_nxt    = tx_sh_r;
    crc_nxt      = crc_r;
    phase_nxt    = phase_r;
    miss_nxt     = miss_r;
    data_nxt     = data_r;
    pend_nxt     = pend_r;
    data_valid_pulse_nxt     = data_valid_pulse_r;
    latch_nxt    = latch_r;
    mask_nxt     = mask_r;
    pol_nxt      = pol_r;
    ctrl_nxt     = {vcc_powered_i, ctrl_r[6:0]};
    waddr_nxt    = waddr_r;
    wdone_nxt    = wdone_r;
    act_clr      = 1'b0;
    rx_byte      = {slot_bit_i, rx_sh_r[7:1]};
    last_bit     = (bit_cnt_r == LAST_BIT);
    crc_upd      = crc_step(crc_r, slot_wr_i ? slot_bit_i : tx_sh_r[0]);
    if (slot_wr_i) begin
      rx_sh_nxt = rx_byte;
    end
    if (slot_rd_i) begin
      tx_sh_nxt = {1'b1, tx_sh_r[7:1]};
    end
    if (slot_wr_i || slot_rd_i) begin
      bit_cnt_nxt = bit_cnt_r + 3'h1;
    end
    // A zero last bit holds the change until the line is back high
    if (slot_end_i && pend_r) begin
      latch_nxt = data_r;
      pend_nxt  = 1'b0;
    end
    case (state_r)
      ST_ROM_CMD: begin
        if (slot_wr_i && last_bit) begin
          byte_cnt_nxt = 5'h00;
          miss_nxt     = 1'b0;
          case (rx_byte)
            CMD_READ_ROM: begin
              state_nxt = ST_READ_ROM;
              tx_sh_nxt = ROM_ID[7:0];
            end
            CMD_MATCH_ROM: state_nxt = ST_MATCH_ROM;
            default:       state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_READ_ROM: begin
        if (slot_rd_i && last_bit) begin
          if (byte_cnt_r == LAST_ROM_BYTE) begin
            state_nxt = ST_IDLE;
          end else begin
            byte_cnt_nxt = byte_cnt_r + 5'h01;
            tx_sh_nxt    = ROM_ID[{byte_cnt_nxt[2:0], 3'h0} +: 8];
          end
        end
      end
      ST_MATCH_ROM: begin
        if (slot_wr_i) begin
          miss_nxt = miss_r |
            (slot_bit_i != ROM_ID[{byte_cnt_r[2:0], bit_cnt_r}]);
          if (last_bit) begin
            byte_cnt_nxt = byte_cnt_r + 5'h01;
            if (byte_cnt_r == LAST_ROM_BYTE) begin
              state_nxt = miss_nxt ? ST_IDLE : ST_FUNC_CMD;
              crc_nxt   = 16'h0000;
            end
          end
        end
      end
      ST_FUNC_CMD: begin
        if (slot_wr_i) begin
          crc_nxt = crc_upd;
          if (last_bit) begin
            byte_cnt_nxt = 5'h00;
            case (rx_byte)
              CMD_CH_READ: begin
                state_nxt = ST_CH_READ;
                tx_sh_nxt = io_channel_i;
                data_valid_pulse_nxt  = 1'b1;
                phase_nxt = 2'd0;
              end
              CMD_CH_WRITE:  state_nxt = ST_WR_DATA;
              CMD_WR_SEARCH: state_nxt = ST_SRCH_ADDR;
              CMD_ACT_RESET: begin
                act_clr   = 1'b1;
                state_nxt = ST_ACT_AA;
                tx_sh_nxt = CONFIRM_BYTE;
              end
              default: state_nxt = ST_IDLE;
            endcase
          end
        end
      end
      ST_CH_READ: begin
        if (slot_rd_i) begin
          if (phase_r == 2'd0) begin
            crc_nxt = crc_upd;
          end
          if (last_bit) begin
            data_valid_pulse_nxt = 1'b0;
            case (phase_r)
              2'd0: begin
                if (byte_cnt_r == LAST_SAMPLE) begin
                  tx_sh_nxt = ~crc_upd[7:0];
                  phase_nxt = 2'd1;
                end else begin
                  tx_sh_nxt    = io_channel_i;
                  byte_cnt_nxt = byte_cnt_r + 5'h01;
                  data_valid_pulse_nxt     = 1'b1;
                end
              end
              2'd1: begin
                tx_sh_nxt = ~crc_r[15:8];
                phase_nxt = 2'd2;
              end
              default: begin
                tx_sh_nxt    = io_channel_i;
                crc_nxt      = 16'h0000;
                byte_cnt_nxt = 5'h00;
                phase_nxt    = 2'd0;
                data_valid_pulse_nxt     = 1'b1;
              end
            endcase
          end
        end
      end
      ST_WR_DATA: begin
        if (slot_wr_i && last_bit) begin
          data_nxt  = rx_byte;
          state_nxt = ST_WR_INV;
        end
      end
      ST_WR_INV: begin
        if (slot_wr_i && last_bit) begin
          if (rx_byte == ~data_r) begin
            if (slot_bit_i) begin
              latch_nxt = data_r;
            end else begin
              pend_nxt = 1'b1;
            end
            tx_sh_nxt = CONFIRM_BYTE;
            data_valid_pulse_nxt  = 1'b1;
            state_nxt = ST_WR_CONF;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WR_CONF: begin
        if (slot_rd_i && last_bit) begin
          tx_sh_nxt = io_channel_i;
          data_valid_pulse_nxt  = 1'b0;
          state_nxt = ST_WR_SAMPLE;
        end
      end
      ST_WR_SAMPLE: begin
        if (slot_rd_i && last_bit) begin
          state_nxt = ST_WR_DATA;
        end
      end
      ST_SRCH_ADDR: begin
        if (slot_wr_i && last_bit) begin
          if (byte_cnt_r == 5'h00) begin
            waddr_nxt    = rx_byte;
            byte_cnt_nxt = 5'h01;
          end else begin
            state_nxt = ST_SRCH_DATA;
            wdone_nxt = !(rx_byte == ADDR_HI && waddr_r >= ADDR_MASK &&
                          waddr_r <= ADDR_CTRL);
          end
        end
      end
      ST_SRCH_DATA: begin
        if (slot_wr_i && last_bit && !wdone_r) begin
          case (waddr_r)
            ADDR_MASK: mask_nxt = rx_byte;
            ADDR_POL:  pol_nxt  = rx_byte;
            default: begin
              ctrl_nxt = {vcc_powered_i, 3'b000,
                          ctrl_r[CTRL_PORL_BIT] & rx_byte[CTRL_PORL_BIT],
                          rx_byte[CTRL_PFS_BIT:CTRL_PLS_BIT]};
            end
          endcase
          if (waddr_r == ADDR_CTRL) begin
            wdone_nxt = 1'b1;
          end else begin
            waddr_nxt = waddr_r + 8'h01;
          end
        end
      end
      ST_ACT_AA: begin
        if (slot_rd_i && last_bit) begin
          tx_sh_nxt = CONFIRM_BYTE;
        end
      end
      ST_IDLE: begin
        tx_sh_nxt = 8'hFF;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (bus_reset_i) begin
      state_nxt   = ST_ROM_CMD;
      bit_cnt_nxt = 3'h0;
      tx_sh_nxt   = 8'hFF;
      pend_nxt    = 1'b0;
      data_valid_pulse_nxt    = 1'b0;
    end
    if (forced_off) begin
      latch_nxt = RST_OUT_LAT;
    end
    // A set in the same cycle as the clear survives
    act_nxt    = (act_clr ? RST_ACT_LAT : act_r) |
                 (io_channel_i ^ pin_q_r);
    pin_q_nxt  = io_channel_i;
    strobe_nxt = data_valid_pulse_mode && data_valid_pulse_nxt &&
                 (bit_cnt_nxt < STROBE_BITS);
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 5'h00;
      rx_sh_r    <= 8'h00;
      tx_sh_r    <= 8'hFF;
      crc_r      <= 16'h0000;
      phase_r    <= 2'd0;
      miss_r     <= 1'b0;
      data_r     <= RST_OUT_LAT;
      pend_r     <= 1'b0;
      data_valid_pulse_r     <= 1'b0;
      strobe_r   <= 1'b0;
      latch_r    <= RST_OUT_LAT;
      act_r      <= RST_ACT_LAT;
      pin_q_r    <= 8'hFF;
      mask_r     <= RST_MASK;
      pol_r      <= RST_POL;
      ctrl_r     <= {1'b0, RST_CTRL};
      waddr_r    <= 8'h00;
      wdone_r    <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      rx_sh_r    <= rx_sh_nxt;
      tx_sh_r    <= tx_sh_nxt;
      crc_r      <= crc_nxt;
      phase_r    <= phase_nxt;
      miss_r     <= miss_nxt;
      data_r     <= data_nxt;
      pend_r     <= pend_nxt;
      data_valid_pulse_r     <= data_valid_pulse_nxt;
      strobe_r   <= strobe_nxt;
      latch_r    <= latch_nxt;
      act_r      <= act_nxt;
      pin_q_r    <= pin_q_nxt;
      mask_r     <= mask_nxt;
      pol_r      <= pol_nxt;
      ctrl_r     <= ctrl_nxt;
      waddr_r    <= waddr_nxt;
      wdone_r    <= wdone_nxt;
    end
  end

  // Open drain: a latch bit of zero turns the pulldown on
  assign tx_bit_o                    = tx_sh_r[0];
  assign io_channel_o                = '0;
  assign io_channel_oe_o             = ~latch_r;
  assign multipurpose_reset_pin_o    = 1'b0;
  assign multipurpose_reset_pin_oe_o = strobe_r;
  assign output_latch_state_o        = latch_r;
  assign activity_latch_state_o      = act_r;
  assign search_channel_mask_o       = mask_r;
  assign search_polarity_select_o    = pol_r;
  assign control_and_status_o        = ctrl_r;

  AST_IDLE_SILENT: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state_r == ST_IDLE) && $past(state_r == ST_IDLE) |-> tx_bit_o)
    else $error("Idle device drove a zero");
  AST_LATCH_SOURCE: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    $changed(latch_r) |-> $past(forced_off) || $past(pend_r) ||
      $past(state_r == ST_WR_INV))
    else $error("Output latch changed outside channel write");
  AST_BAD_COMPLEMENT: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state_r == ST_WR_INV) && slot_wr_i && last_bit &&
      (rx_byte != ~data_r) && !forced_off && !pend_r && !bus_reset_i
    |=> (state_r == ST_IDLE) && $stable(latch_r))
    else $error("Bad complement changed outputs");
  AST_APPLY_CONFIRM: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state_r == ST_WR_INV) && slot_wr_i && last_bit && slot_bit_i &&
      (rx_byte == ~data_r) && !forced_off && !bus_reset_i
    |=> (latch_r == $past(data_r)) && (tx_sh_r == CONFIRM_BYTE))
    else $error("Update or confirmation missing");
  AST_STROBE_MODE: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    multipurpose_reset_pin_oe_o |-> $past(data_valid_pulse_mode) && (bit_cnt_r < 3'h2))
    else $error("Strobe outside strobe mode or window");
  AST_ACT_CLEAR: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    act_clr && (io_channel_i == pin_q_r) |=> (act_r == 8'h00))
    else $error("Activity latches not cleared");
  AST_ACT_SET: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (io_channel_i != pin_q_r) |=>
      ((act_r & $past(io_channel_i ^ pin_q_r)) ==
        $past(io_channel_i ^ pin_q_r)))
    else $error("Pin transition did not set activity latch");
  AST_FORCED_OFF: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    forced_off |=> (latch_r == 8'hFF) && (io_channel_oe_o == 8'h00))
    else $error("Reset input did not force outputs off");
  AST_SEARCH_STOP: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state_r == ST_SRCH_DATA) && wdone_r
    |=> $stable(mask_r) && $stable(pol_r) && $stable(ctrl_r[6:0]))
    else $error("Search register written after last address");
  AST_CRC_AFTER_32: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state_r == ST_CH_READ) && slot_rd_i && last_bit && !bus_reset_i &&
      (phase_r == 2'd0) && (byte_cnt_r == 5'h1F)
    |=> (phase_r == 2'd1) && (tx_sh_r == ~$past(crc_upd[7:0])))
    else $error("CRC not sent after 32 samples");
endmodule // pce_engine

// ===== sim/pce_master.sv
// Bus master model that issues every slot seen by the engine
`timescale 1ns/1ns
module pce_master (
  input  wire logic clk_i,
  input  wire logic tx_bit_i,
  output logic      bus_reset_o,
  output logic      slot_wr_o,
  output logic      slot_bit_o,
  output logic      slot_rd_o,
  output logic      slot_end_o
);
  // Idle cycles between slots, zero gives back to back slots
  int gap = 0;
  initial begin
    {bus_reset_o, slot_wr_o, slot_bit_o, slot_rd_o, slot_end_o} = 5'h00;
  end
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic bus_reset();
    bus_reset_o = 1'b1;
    tick();
    bus_reset_o = 1'b0;
    tick();
  endtask
  // One slot; the bit line flips once released so stale data never passes
  task automatic slot(input logic rd, input logic b, output logic q);
    q = tx_bit_i;
    slot_wr_o = !rd;
    slot_rd_o = rd;
    slot_bit_o = b;
    tick();
    slot_wr_o = 1'b0;
    slot_rd_o = 1'b0;
    slot_end_o = 1'b1;
    slot_bit_o = !b;
    tick();
    slot_end_o = 1'b0;
    repeat (gap) tick();
  endtask
  task automatic wr(input logic [7:0] d);
    logic q;
    for (int i = 0; i < 8; i++) slot(1'b0, d[i], q);
  endtask
  task automatic rd(output logic [7:0] d);
    for (int i = 0; i < 8; i++) slot(1'b1, 1'b1, d[i]);
  endtask
endmodule // pce_master

// ===== sim/tb.sv
// Self-checking bench for the channel command engine
`timescale 1ns/1ns
`define CHK(n, e, s) \
  begin checked++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  import pce_pkg::*;
  // Identity value is arbitrary
  localparam logic [63:0] ID = 64'h1234_5678_9ABC_DE21;
  logic clk, rst_n, tx, bres, swr, sbit, srd, send, mrp_ext, mrp_o, mrp_oe;
  logic [7:0] ext, ch_o, oe, latch, act, mask, pol, ctrl, hist, b, lo, hi;
  logic [15:0] c;
  logic        vcc;
  int checked = 0;
  int miscompares = 0;
  pce_engine #(.ROM_ID(ID)) dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .bus_reset_i(bres),
    .slot_wr_i(swr), .slot_bit_i(sbit), .slot_rd_i(srd),
    .slot_end_i(send), .tx_bit_o(tx), .io_channel_i(ext & ~oe),
    .io_channel_o(ch_o), .io_channel_oe_o(oe),
    .multipurpose_reset_pin_i(mrp_ext & ~mrp_oe),
    .multipurpose_reset_pin_o(mrp_o), .multipurpose_reset_pin_oe_o(mrp_oe),
    .vcc_powered_i(vcc), .output_latch_state_o(latch),
    .activity_latch_state_o(act), .search_channel_mask_o(mask),
    .search_polarity_select_o(pol), .control_and_status_o(ctrl));
  pce_master mst (.clk_i(clk), .tx_bit_i(tx), .bus_reset_o(bres),
    .slot_wr_o(swr), .slot_bit_o(sbit), .slot_rd_o(srd), .slot_end_o(send));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Strobe level at each read sample, oldest bit highest
  always @(posedge clk) if (srd) hist <= {hist[6:0], mrp_oe};
  function automatic logic [15:0] crc(input logic [15:0] r,
                                      input logic [7:0]  d);
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction
  task automatic sel(input logic [63:0] id);
    mst.bus_reset();
    mst.wr(CMD_MATCH_ROM);
    for (int i = 0; i < 8; i++) mst.wr(id[8*i +: 8]);
  endtask
  // Data byte, its inverse, then confirmation and read-back
  task automatic chw(input logic [7:0] d, input logic [7:0] h);
    mst.wr(d);
    mst.wr(~d);
    mst.rd(b);
    `CHK("confirm", 8'hAA, b)
    `CHK("strobe", {h, 1'b0}, {hist, mrp_o})
    `CHK("latch", {d, ~d, 8'h00}, {latch, oe, ch_o})
    mst.rd(b);
    `CHK("readback", d & ext, b)
    `CHK("nostrobe", 8'h00, hist)
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    ext = 8'hFF;
    mrp_ext = 1'b1;
    vcc = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) mst.tick();
    `CHK("resets", 40'hFF00000088, {latch, act, mask, pol, ctrl})
    // Supply status bit follows the pin one edge later
    vcc = 1'b0;
    mst.tick();
    `CHK("vccp", 8'h08, ctrl)
    vcc = 1'b1;
    mst.bus_reset();
    mst.wr(CMD_READ_ROM);
    for (int i = 0; i < 8; i++) begin
      mst.rd(b);
      `CHK("rom", ID[8*i +: 8], b)
    end
    // Write loop in reset-input mode, second pass with idle gaps
    sel(ID);
    mst.wr(CMD_CH_WRITE);
    chw(8'hA5, 8'h00);
    mst.gap = 3;
    chw(8'h0F, 8'h00);
    mst.gap = 0;
    `CHK("activity", 8'hFA, act)
    mst.wr(8'h00);
    mst.wr(8'h01);
    mst.tick();
    `CHK("badinv", 8'h0F, latch)
    mrp_ext = 1'b0;
    repeat (2) mst.tick();
    `CHK("forced", 16'hFF00, {latch, oe})
    mrp_ext = 1'b1;
    sel(ID);
    mst.wr(CMD_WR_SEARCH);
    mst.wr(ADDR_MASK);
    mst.wr(ADDR_HI);
    mst.wr(8'h5A);
    mst.wr(8'h5A);
    mst.wr(8'h04);
    mst.wr(8'hFF);
    `CHK("search", 16'h5A5A, {mask, pol})
    `CHK("ctrl", 8'h84, ctrl)
    sel(ID);
    mst.wr(CMD_CH_WRITE);
    chw(8'hC3, 8'hC0);
    sel(ID);
    mst.wr(CMD_ACT_RESET);
    mst.tick();
    `CHK("actclr", 8'h00, act)
    for (int i = 0; i < 2; i++) begin
      mst.rd(b);
      `CHK("actack", 8'hAA, b)
    end
    ext = 8'hF0;
    sel(ID);
    mst.wr(CMD_CH_READ);
    ext = 8'h0F;
    c = crc(16'h0000, CMD_CH_READ);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 32; i++) begin
        mst.rd(b);
        `CHK("sample", (p == 0 && i == 0) ? 8'hC0 : 8'h03, b)
        if (i == 0) `CHK("rdstrobe", 8'hC0, hist)
        c = crc(c, b);
      end
      mst.rd(lo);
      mst.rd(hi);
      `CHK("crc", ~c, {hi, lo})
      c = 16'h0000;
    end
    sel(~ID);
    mst.wr(CMD_CH_WRITE);
    mst.wr(8'h00);
    mst.wr(8'hFF);
    mst.rd(b);
    `CHK("silent", 16'hFFC3, {b, latch})
    sel(ID);
    mst.wr(CMD_WR_SEARCH);
    mst.wr(ADDR_OUT_LAT);
    mst.wr(ADDR_HI);
    mst.wr(8'h00);
    `CHK("onlywrite", 8'hC3, latch)
    // Mid-run reset must bring every register back to its reset value
    ext = 8'hFF;
    rst_n = 1'b0;
    repeat (2) mst.tick();
    rst_n = 1'b1;
    repeat (2) mst.tick();
    `CHK("rerun", 40'hFF00000088, {latch, act, mask, pol, ctrl})
    close_out();
  end
endmodule // tb
